// ==== core/long_call_and_misc_instr.sv ====
// Decoder and executor for the two long subroutine calls, the LED port set
// and the accumulator complement of a 4-bit core.
// Assumes instruction words arrive from fetch logic on CORE_CLK, one per valid cycle,
// each belonging to the address shown on PC_PAGE/PC_INPAGE.
// Assumes the data pointer, register loads and stack read index are same-clock.
// Done and error outputs pulse for one cycle; the others hold until changed.
`timescale 1ns/1ps
`default_nettype none
module long_call_and_misc_instr
  import call_decode_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire instr_word_s       INSTR,
  input  wire reg_load_s         REG_LOAD,
  input  wire logic [DP_W-1:0]   DATA_POINTER_BITS,
  input  wire logic [SP_W-1:0]   STACK_RD_INDEX,
  output var  logic [PAGE_W-1:0] PC_PAGE_PART,
  output var  logic [INPAGE_W-1:0] PC_INPAGE_PART,
  output var  logic [SP_W-1:0]   STACK_POINTER,
  output var  logic [PC_W-1:0]   STACK_RD_DATA,
  output var  logic [ACC_W-1:0]  ACCUMULATOR,
  output var  logic              CARRY_FLAG,
  output var  logic [LED_W-1:0]  LED_PORT,
  output var  logic              SKIP_NEXT,
  output var  logic              CALL_DONE,
  output var  logic              PAGE_RANGE_ERR,
  output var  logic              SECOND_WORD_ERR
);

  typedef struct packed {
    dec_state_e          state;
    logic [PAGE_W-2:0]   page_low;
    logic [PC_W-1:0]     pc;
    logic [SP_W-1:0]     sp;
    logic [ACC_W-1:0]    acc;
    logic                carry;
    logic [LED_W-1:0]    led;
    logic                skip;
    logic                call_done;
    logic                page_err;
    logic                second_err;
  } core_state_s;

  core_state_s st_q;
  core_state_s st_d;

  logic                push_en;
  logic [SP_W-1:0]     push_idx;
  logic [PC_W-1:0]     push_data;

  logic [PC_W-1:0]     pc_next_seq;
  logic [WORD_W-1:0]   w;
  logic                second_ok;
  logic [PAGE_W-1:0]   page_fixed;
  logic [PAGE_W-1:0]   page_ind;
  logic [INPAGE_W-1:0] inpage_ind;
  logic                is_fixed_first;
  logic                is_ind_first;
  logic                is_set_led;
  logic                is_compl_acc;
  logic                ind_spacer_ok;
  logic                fixed_page_high;
  logic                ind_page_high;

  // Sequential address: in-page part wraps into the page part
  assign pc_next_seq = PC_W'(st_q.pc + PC_W'(1));
  assign w           = INSTR.word;
  assign second_ok   = (w[SECOND_PRE_LSB +: 2] == SECOND_PREFIX);
  assign page_fixed  = {w[FIXED_P5_BIT], st_q.page_low};
  assign page_ind    = {w[IND_PHI_LSB +: 2], w[IND_PLO_LSB +: 4]};
  assign inpage_ind  = {DATA_POINTER_BITS, st_q.acc};

  // First-word decode; only looked at while no call is half taken
  assign is_fixed_first  = (w[FIXED_PRE_LSB +: 5] == FIXED_PREFIX);
  assign is_ind_first    = (w == INDIRECT_WORD);
  assign is_set_led      = (w == SET_LED_WORD);
  assign is_compl_acc    = (w == COMPL_ACC_WORD);
  // A set spacer bit marks a malformed indirect second word, not a call
  assign ind_spacer_ok   = (w[IND_ZERO_LSB +: 2] == 2'h0);
  // Pages above the top one are still entered; the flags let the core trap them
  assign fixed_page_high = (page_fixed > PAGE_W'(PAGE_MAX));
  assign ind_page_high   = (page_ind > PAGE_W'(PAGE_MAX));

  // Call timing, one valid word per cycle:
  //   first word edge  - a fixed call keeps the low page bits; both wait for the second word
  //   second word edge - bump the stack pointer, push the return address,
  //                      load the target and pulse the completion flag
  // The pushed address follows the second word, so a return resumes
  // behind the whole call. A cycle without a valid word leaves a
  // half-taken call waiting; a malformed second word abandons it.

  always_comb begin
    st_d            = st_q;
    push_en         = 1'b0;
    push_idx        = st_q.sp;
    // Return address: the word after the call's second word
    push_data       = pc_next_seq;
    st_d.call_done  = 1'b0;
    st_d.page_err   = 1'b0;
    st_d.second_err = 1'b0;
    // None of these instructions requests a skip
    st_d.skip       = 1'b0;

    // Loads from the rest of the core; they lose to an instruction in the same cycle
    if (REG_LOAD.acc_load) begin
      st_d.acc = REG_LOAD.acc_value;
    end
    if (REG_LOAD.carry_load) begin
      st_d.carry = REG_LOAD.carry_value;
    end
    if (REG_LOAD.led_load) begin
      st_d.led = REG_LOAD.led_value;
    end

    if (INSTR.valid) begin
      st_d.pc = pc_next_seq;
      case (st_q.state)
        ST_OPCODE: begin
          // Any other word only moves the program counter on
          if (is_fixed_first) begin
            st_d.page_low = w[PAGE_W-2:0];
            st_d.state    = ST_FIXED_SECOND;
          end else if (is_ind_first) begin
            st_d.state = ST_IND_SECOND;
          end else if (is_set_led) begin
            st_d.led = '1;
          end else if (is_compl_acc) begin
            st_d.acc = ~st_q.acc;
          end
        end
        ST_FIXED_SECOND: begin
          st_d.state = ST_OPCODE;
          if (second_ok) begin
            st_d.sp        = SP_W'(st_q.sp + SP_W'(1));
            push_en        = 1'b1;
            push_idx       = SP_W'(st_q.sp + SP_W'(1));
            st_d.pc        = {page_fixed, w[INPAGE_W-1:0]};
            st_d.call_done = 1'b1;
            st_d.page_err  = fixed_page_high;
          end else begin
            st_d.second_err = 1'b1;
          end
        end
        ST_IND_SECOND: begin
          st_d.state = ST_OPCODE;
          // The two spacer bits must read zero as well as the prefix
          if (second_ok && ind_spacer_ok) begin
            st_d.sp        = SP_W'(st_q.sp + SP_W'(1));
            push_en        = 1'b1;
            push_idx       = SP_W'(st_q.sp + SP_W'(1));
            // Page from the word, in-page part from D above A
            st_d.pc        = {page_ind, inpage_ind};
            st_d.call_done = 1'b1;
            st_d.page_err  = ind_page_high;
          end else begin
            st_d.second_err = 1'b1;
          end
        end
        default: begin
          st_d.state = ST_OPCODE;
        end
      endcase
    end
  end

  // Only constants in the reset branch; the stack module clears its own entries
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_q.state      <= ST_OPCODE;
      st_q.page_low   <= '0;
      st_q.pc         <= PC_RESET;
      st_q.sp         <= SP_RESET;
      st_q.acc        <= ACC_RESET;
      st_q.carry      <= 1'b0;
      st_q.led        <= LED_RESET;
      st_q.skip       <= 1'b0;
      st_q.call_done  <= 1'b0;
      st_q.page_err   <= 1'b0;
      st_q.second_err <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Stack overflow wraps silently, as the hardware gives no depth check
  return_stack_file #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W),
    .IDX_W (SP_W)
  ) u_return_stack (
    .clk     (CORE_CLK),
    .rst     (RESET),
    .wr_en   (push_en),
    .wr_idx  (push_idx),
    .wr_data (push_data),
    .rd_idx  (STACK_RD_INDEX),
    .rd_data (STACK_RD_DATA)
  );

  // Each output is a state bit; no logic sits between register and pin
  assign PC_PAGE_PART    = st_q.pc[PC_W-1:INPAGE_W];
  assign PC_INPAGE_PART  = st_q.pc[INPAGE_W-1:0];
  assign STACK_POINTER   = st_q.sp;
  assign ACCUMULATOR     = st_q.acc;
  assign CARRY_FLAG      = st_q.carry;
  assign LED_PORT        = st_q.led;
  assign SKIP_NEXT       = st_q.skip;
  assign CALL_DONE       = st_q.call_done;
  assign PAGE_RANGE_ERR  = st_q.page_err;
  assign SECOND_WORD_ERR = st_q.second_err;

endmodule : long_call_and_misc_instr
`default_nettype wire

// ==== pkg/call_decode_pkg.sv ====
// Constants and carriers shared by the long-call and miscellaneous instruction core.
// Assumes 10-bit instruction words supplied one per clock by same-clock fetch logic.
package call_decode_pkg;

  localparam int unsigned WORD_W      = 10;
  localparam int unsigned PAGE_W      = 6;
  localparam int unsigned INPAGE_W    = 7;
  localparam int unsigned PC_W        = PAGE_W + INPAGE_W;
  localparam int unsigned SP_W        = 3;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned ACC_W       = 4;
  localparam int unsigned DP_W        = 3;
  localparam int unsigned LED_W       = 8;

  // First words
  localparam logic [4:0]        FIXED_PREFIX   = 5'h06;
  localparam int unsigned       FIXED_PRE_LSB  = 5;
  localparam logic [WORD_W-1:0] INDIRECT_WORD  = 10'h030;
  localparam logic [WORD_W-1:0] SET_LED_WORD   = 10'h011;
  localparam logic [WORD_W-1:0] COMPL_ACC_WORD = 10'h01C;

  // Second word fields
  localparam logic [1:0]  SECOND_PREFIX    = 2'h2;
  localparam int unsigned SECOND_PRE_LSB   = 8;
  localparam int unsigned FIXED_P5_BIT     = 7;
  localparam int unsigned IND_PHI_LSB      = 6;
  localparam int unsigned IND_ZERO_LSB     = 4;
  localparam int unsigned IND_PLO_LSB      = 0;
  localparam int unsigned PAGE_MAX         = 47;

  // Reset values
  localparam logic [PC_W-1:0]  PC_RESET  = 13'h0000;
  localparam logic [SP_W-1:0]  SP_RESET  = 3'h0;
  localparam logic [ACC_W-1:0] ACC_RESET = 4'h0;
  localparam logic [LED_W-1:0] LED_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_OPCODE       = 2'b00,
    ST_FIXED_SECOND = 2'b01,
    ST_IND_SECOND   = 2'b10
  } dec_state_e;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] word;
  } instr_word_s;

  typedef struct packed {
    logic               acc_load;
    logic [ACC_W-1:0]   acc_value;
    logic               carry_load;
    logic               carry_value;
    logic               led_load;
    logic [LED_W-1:0]   led_value;
  } reg_load_s;

endpackage : call_decode_pkg

// ==== core/return_stack_file.sv ====
// Return stack storage: flip-flop entries, one write port and a registered read port.
// Assumes the caller keeps the write index inside the depth.
`timescale 1ns/1ps
`default_nettype none
module return_stack_file #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 13,
  parameter int unsigned IDX_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output var  logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] entry;
    logic [WIDTH-1:0]            rd;
  } stack_state_s;

  stack_state_s st_q;
  stack_state_s st_d;

  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.entry[wr_idx] = wr_data;
    end
    // Read sees the old entry on a same-cycle write
    st_d.rd = st_q.entry[rd_idx];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd;

endmodule : return_stack_file
`default_nettype wire

// ==== verification/long_call_assertions.sv ====
// Checker for the long-call and miscellaneous instruction core.
// Sees only the top ports; tracks first/second call words itself.
`timescale 1ns/1ps
`default_nettype none
module long_call_checker
  import call_decode_pkg::*;
(
  input wire logic                CORE_CLK,
  input wire logic                RESET,
  input wire instr_word_s         INSTR,
  input wire reg_load_s           REG_LOAD,
  input wire logic [DP_W-1:0]     DATA_POINTER_BITS,
  input wire logic [SP_W-1:0]     STACK_RD_INDEX,
  input wire logic [PAGE_W-1:0]   PC_PAGE_PART,
  input wire logic [INPAGE_W-1:0] PC_INPAGE_PART,
  input wire logic [SP_W-1:0]     STACK_POINTER,
  input wire logic [PC_W-1:0]     STACK_RD_DATA,
  input wire logic [ACC_W-1:0]    ACCUMULATOR,
  input wire logic                CARRY_FLAG,
  input wire logic [LED_W-1:0]    LED_PORT,
  input wire logic                SKIP_NEXT,
  input wire logic                CALL_DONE,
  input wire logic                PAGE_RANGE_ERR,
  input wire logic                SECOND_WORD_ERR
);
  logic            pend_q, ind_q, go, fst, sec_ok, bad;
  logic [4:0]      plo_q;
  logic [PC_W-1:0] tgt_q, pc;
  assign pc = {PC_PAGE_PART, PC_INPAGE_PART};
  assign go = !RESET && INSTR.valid;
  assign fst = go && !pend_q;
  assign sec_ok = go && pend_q && INSTR.word[9:8] == SECOND_PREFIX
                  && (!ind_q || INSTR.word[5:4] == 2'h0);
  assign bad = go && pend_q && !sec_ok;
  // Target is captured from D and A as they stand at the second-word edge
  always_ff @(posedge CORE_CLK) begin
    if (RESET) pend_q <= 1'b0;
    else if (go) pend_q <= !pend_q && (INSTR.word[9:5] == FIXED_PREFIX
                                      || INSTR.word == INDIRECT_WORD);
    if (fst) ind_q <= INSTR.word == INDIRECT_WORD;
    if (fst) plo_q <= INSTR.word[4:0];
    if (sec_ok) tgt_q <= ind_q ? {INSTR.word[7:6], INSTR.word[3:0], DATA_POINTER_BITS,
      ACCUMULATOR} : {INSTR.word[7], plo_q, INSTR.word[6:0]};
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  cmpl_acc_a: assert property (fst && INSTR.word == COMPL_ACC_WORD |=>
    ACCUMULATOR == ~$past(ACCUMULATOR) && pc == $past(pc) + 13'h1)
    else $error("complement wrong");
  led_set_a: assert property (fst && INSTR.word == SET_LED_WORD |=> LED_PORT == 8'hFF)
    else $error("led port not all ones");
  push_sp_a: assert property (sec_ok |=> STACK_POINTER == $past(STACK_POINTER) + 3'h1
    && CALL_DONE) else $error("call push wrong");
  call_tgt_a: assert property (CALL_DONE |-> pc == tgt_q)
    else $error("call target wrong");
  call_only_a: assert property (CALL_DONE |-> $past(sec_ok))
    else $error("stray call done");
  page_err_a: assert property (CALL_DONE |-> PAGE_RANGE_ERR == (PC_PAGE_PART > 6'h2F))
    else $error("page range flag wrong");
  bad_second_a: assert property (bad |=> SECOND_WORD_ERR && !CALL_DONE
    && $stable(STACK_POINTER)) else $error("bad second word taken");
  carry_hold_a: assert property (!REG_LOAD.carry_load |=> $stable(CARRY_FLAG))
    else $error("carry changed");
  no_skip_a: assert property (!SKIP_NEXT) else $error("skip raised");
endmodule : long_call_checker
bind long_call_and_misc_instr long_call_checker u_chk (.CORE_CLK, .RESET, .INSTR, .REG_LOAD,
  .DATA_POINTER_BITS, .STACK_RD_INDEX, .PC_PAGE_PART, .PC_INPAGE_PART, .STACK_POINTER,
  .STACK_RD_DATA, .ACCUMULATOR, .CARRY_FLAG, .LED_PORT, .SKIP_NEXT, .CALL_DONE,
  .PAGE_RANGE_ERR, .SECOND_WORD_ERR);
`default_nettype wire

// ==== verification/tb_long_call_and_misc_instr.sv ====
// Testbench for the long-call and miscellaneous instruction core.
// Drives inputs at the falling edge; results are read one cycle after a word.
`timescale 1ns/1ps
`default_nettype none
module tb_long_call_and_misc_instr
  import call_decode_pkg::*;
;
  logic                CORE_CLK = 1'b0, RESET = 1'b1;
  instr_word_s         INSTR = '0;
  reg_load_s           REG_LOAD = '0;
  logic [DP_W-1:0]     DATA_POINTER_BITS = 3'h6;
  logic [SP_W-1:0]     STACK_RD_INDEX = 3'h0, STACK_POINTER;
  logic [PAGE_W-1:0]   PC_PAGE_PART;
  logic [INPAGE_W-1:0] PC_INPAGE_PART;
  logic [PC_W-1:0]     STACK_RD_DATA, pc;
  logic [ACC_W-1:0]    ACCUMULATOR;
  logic [LED_W-1:0]    LED_PORT;
  logic                CARRY_FLAG, SKIP_NEXT, CALL_DONE, PAGE_RANGE_ERR, SECOND_WORD_ERR;
  int                  fails = 0, checks = 0;
  always #25 CORE_CLK = ~CORE_CLK;
  long_call_and_misc_instr u_dut (.CORE_CLK, .RESET, .INSTR, .REG_LOAD, .DATA_POINTER_BITS,
    .STACK_RD_INDEX, .PC_PAGE_PART, .PC_INPAGE_PART, .STACK_POINTER, .STACK_RD_DATA,
    .ACCUMULATOR, .CARRY_FLAG, .LED_PORT, .SKIP_NEXT, .CALL_DONE, .PAGE_RANGE_ERR,
    .SECOND_WORD_ERR);
  task automatic chk(input string n, input logic [PC_W-1:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Words go out back to back; the expected PC follows each one
  task automatic step(input logic [WORD_W-1:0] w);
    INSTR = {1'b1, w};
    @(negedge CORE_CLK);
    pc = pc + 13'h1;
  endtask : step
  task automatic idle;
    INSTR.valid = 1'b0;
    @(negedge CORE_CLK);
  endtask : idle
  task automatic t_misc;
    REG_LOAD = '{1'b1, 4'h5, 1'b1, 1'b1, 1'b1, 8'h3C};
    @(negedge CORE_CLK);
    REG_LOAD = '0;
    chk("led", 13'h003C, LED_PORT);
    step(COMPL_ACC_WORD);
    chk("acc", 13'h000A, ACCUMULATOR);
    chk("pc", pc, {PC_PAGE_PART, PC_INPAGE_PART});
    step(SET_LED_WORD);
    chk("led", 13'h00FF, LED_PORT);
    chk("pc", pc, {PC_PAGE_PART, PC_INPAGE_PART});
    idle();
    $display("misc test done");
  endtask : t_misc
  task automatic t_call(input logic ind, input logic [5:0] p, input logic [6:0] a);
    logic [PC_W-1:0] ret;
    logic [SP_W-1:0] sp;
    sp = STACK_POINTER;
    if (ind) a = {DATA_POINTER_BITS, ACCUMULATOR};
    step(ind ? INDIRECT_WORD : {FIXED_PREFIX, p[4:0]});
    step(ind ? {2'h2, p[5:4], 2'h0, p[3:0]} : {2'h2, p[5], a});
    ret = pc;
    pc = {p, a};
    chk("done", 13'h0001, CALL_DONE);
    chk("perr", 13'(p > 6'h2F), PAGE_RANGE_ERR);
    chk("pc", pc, {PC_PAGE_PART, PC_INPAGE_PART});
    chk("sp", 13'(sp + 3'h1), STACK_POINTER);
    STACK_RD_INDEX = STACK_POINTER;
    idle();
    chk("push", ret, STACK_RD_DATA);
    chk("carry", 13'h0001, CARRY_FLAG);
    chk("skip", 13'h0000, SKIP_NEXT);
    $display("call test done");
  endtask : t_call
  task automatic t_bad(input logic [WORD_W-1:0] w1, w2);
    logic [SP_W-1:0] sp;
    sp = STACK_POINTER;
    step(w1);
    step(w2);
    chk("err", 13'h0001, SECOND_WORD_ERR);
    chk("sp", 13'(sp), STACK_POINTER);
    chk("pc", pc, {PC_PAGE_PART, PC_INPAGE_PART});
    idle();
    $display("bad word test done");
  endtask : t_bad
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(negedge CORE_CLK);
    RESET = 1'b0;
    pc = 13'h0000;
    t_misc();
    t_call(1'b0, 6'h2F, 7'h7F);
    t_call(1'b0, 6'h30, 7'h00);
    t_call(1'b1, 6'h12, 7'h00);
    DATA_POINTER_BITS = 3'h3;
    t_call(1'b1, 6'h31, 7'h00);
    t_bad({FIXED_PREFIX, 5'h01}, 10'h1FF);
    t_bad(INDIRECT_WORD, 10'h230);
    print_verdict();
  end
  // Cuts a hang short
  initial begin
    #1ms;
    fails++;
    print_verdict();
  end
endmodule : tb_long_call_and_misc_instr
`default_nettype wire
